// [pkg/scru_cfg.svh]
// Constants of the SDRAM configuration, refresh and command unit:
// register byte addresses, field positions, reset values, codes, timing.
// Assumes a 32-bit Wishbone address space with full address decode.
`ifndef SCRU_CFG_SVH
`define SCRU_CFG_SVH

// ==========================================================================
// Register byte addresses
`define SCRU_ADDR_SETUP     32'hCC000000
`define SCRU_ADDR_INTERVAL  32'hCC000004
`define SCRU_ADDR_COMMAND   32'hCC000008
`define SCRU_ADDR_STATUS    32'hCC00000C

// ==========================================================================
// Reset values
`define SCRU_SETUP_RST      32'h00000000
`define SCRU_INTERVAL_RST   16'h0384

// ==========================================================================
// Field positions of memory_setup
`define SCRU_SIZE_MSB       2
`define SCRU_SIZE_LSB       0
`define SCRU_CAS3_BIT       3
`define SCRU_TECH64_BIT     5

// ==========================================================================
// Field positions of the status register
`define SCRU_ST_SEQ_BUSY    0
`define SCRU_ST_REF_PEND    1
`define SCRU_ST_CMD_PEND    2
`define SCRU_ST_ACT_HOLD    3
`define SCRU_ST_SETUP_OK    4

// ==========================================================================
// Command codes of memory_command
`define SCRU_CMD_MRS2       3'h0
`define SCRU_CMD_MRS3       3'h1
`define SCRU_CMD_PRE        3'h2
`define SCRU_CMD_NOP        3'h3
`define SCRU_CMD_AR         3'h4
`define SCRU_CMD_BT         3'h5

// ==========================================================================
// Address-line codes: mode words burst 8, sequential, standard, single-location writes; precharge all
`define SCRU_MODE_CL2       13'h0223
`define SCRU_MODE_CL3       13'h0233
`define SCRU_PRE_ALL        13'h0400

// ==========================================================================
// Timing in controller clocks
`define SCRU_MRS_GAP_CLK    3

`endif

// [pkg/scru_pkg.sv]
// Types shared by the SDRAM configuration, refresh and command unit.
// Assumes the constants header is compiled alongside.
package scru_pkg;

  // ========================================================================
  // Operation driven onto the SDRAM command pins for one clock.
  typedef enum logic [2:0] {
    SCRU_OP_DESEL,
    SCRU_OP_MRS2,
    SCRU_OP_MRS3,
    SCRU_OP_PRE,
    SCRU_OP_NOP,
    SCRU_OP_AR,
    SCRU_OP_BT
  } scru_op_t;

  // Active-low SDRAM command strobes travelling together.
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
  } scru_pins_t;

  // Refresh and command sequencer states.
  typedef enum logic [1:0] {
    SCRU_ST_IDLE,
    SCRU_ST_RP,
    SCRU_ST_RC
  } scru_state_t;

endpackage

// [rtl/scru_cmd_encoder.sv]
// Registered encoder from an operation to SDRAM strobes and address code.
// Assumes the SDRAM samples its pins on the controller clock.
`timescale 1ns/1ps
`include "scru_cfg.svh"

module scru_cmd_encoder #(
  parameter int AW = 13
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Operation for the next clock
  input  scru_pkg::scru_op_t     op,
  // SDRAM pins
  output scru_pkg::scru_pins_t   pins,
  output logic [AW-1:0]          addr
);

  scru_pkg::scru_pins_t pinsNxt;
  logic [AW-1:0]        addrNxt;

  // ========================================================================
  // Strobe levels and address code per operation; deselect when idle.
  always_comb begin
    pinsNxt = 4'hF;
    addrNxt = '0;
    case (op)
      scru_pkg::SCRU_OP_MRS2: begin
        pinsNxt = 4'h0;
        addrNxt = AW'(`SCRU_MODE_CL2);
      end
      scru_pkg::SCRU_OP_MRS3: begin
        pinsNxt = 4'h0;
        addrNxt = AW'(`SCRU_MODE_CL3);
      end
      scru_pkg::SCRU_OP_PRE: begin
        pinsNxt = 4'h2;
        addrNxt = AW'(`SCRU_PRE_ALL);
      end
      scru_pkg::SCRU_OP_NOP: pinsNxt = 4'h7;
      scru_pkg::SCRU_OP_AR:  pinsNxt = 4'h1;
      scru_pkg::SCRU_OP_BT:  pinsNxt = 4'h6;
      default:               pinsNxt = 4'hF;
    endcase
  end

  // ========================================================================
  // Output flops keep the pins glitch free.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pins <= 4'hF;
      addr <= '0;
    end else begin
      pins <= pinsNxt;
      addr <= addrNxt;
    end
  end

  // ========================================================================
  // Checks.
  property p_ar_pins;
    @(posedge ref_clk) disable iff (rst)
    op == scru_pkg::SCRU_OP_AR |=> pins == 4'h1;
  endproperty
  a_ar_pins: assert property (p_ar_pins)
    else $error("Auto-refresh strobes wrong.");

endmodule

// [rtl/scru_refresh_timer.sv]
// Refresh interval timer: counts down the programmed interval and pulses
// expire once per interval. Assumes interval comes from a same-clock flop.
`timescale 1ns/1ps
`include "scru_cfg.svh"

module scru_refresh_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Programmed terminal count and its write strobe
  input  wire logic [W-1:0] interval,
  input  wire logic         reload,
  // One-cycle refresh request
  output logic              expire
);

  logic [W-1:0] cnt_r;
  logic         reloadDly_r;

  // ========================================================================
  // Write strobe delayed one clock. The interval flop is written on the
  // same edge as the strobe, so loading at the strobe takes the old count.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reloadDly_r <= 1'b0;
    end else begin
      reloadDly_r <= reload;
    end
  end

  // ========================================================================
  // Counter. Zero in the interval stops all requests; a rewrite restarts.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= W'(`SCRU_INTERVAL_RST);
      expire <= 1'b0;
    end else if (reloadDly_r || interval == '0) begin
      cnt_r  <= interval;
      expire <= 1'b0;
    end else if (cnt_r <= W'(1)) begin
      cnt_r  <= interval;
      expire <= 1'b1;
    end else begin
      cnt_r  <= cnt_r - W'(1);
      expire <= 1'b0;
    end
  end

  // ========================================================================
  // Checks.
  property p_ref_off;
    @(posedge ref_clk) disable iff (rst)
    (interval == '0) [*2] |-> !expire;
  endproperty
  a_ref_off: assert property (p_ref_off)
    else $error("Refresh request while interval is zero.");

  property p_reload;
    @(posedge ref_clk) disable iff (rst)
    expire && !reloadDly_r |-> cnt_r == interval;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Timer not reloaded on expiry.");

endmodule

// [rtl/scru_top.sv]
// SDRAM configuration, refresh timing and software command unit.
// Assumes a classic Wishbone master on ref_clk and an access engine on the
// same clock that reports accessBusy and honours the outputs below.
`timescale 1ns/1ps
`include "scru_cfg.svh"

module scru_top #(
  parameter int AW     = 13,
  parameter int RP_CYC = 3,
  parameter int RC_CYC = 8
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // Wishbone classic slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [31:0]   adr_i,
  input  wire logic [31:0]   dat_i,
  input  wire logic [3:0]    sel_i,
  output logic [31:0]        dat_o,
  output logic               ack_o,
  // Access engine side
  input  wire logic          accessBusy,
  output logic               refreshBusy,
  output logic               pageInvalidate,
  output logic               activateOk,
  output logic               casLatency3,
  output logic [2:0]         memSize,
  output logic               tech64,
  output logic               setupValid,
  // SDRAM pins
  output logic               sdrCsN,
  output logic               sdrRasN,
  output logic               sdrCasN,
  output logic               sdrWeN,
  output logic [AW-1:0]      sdrAddr
);

  // ========================================================================
  // Declarations
  logic [31:0]            setup_r;
  logic [15:0]            interval_r;
  logic [2:0]             cmdCode_r;
  logic                   cmdPend_r;
  logic                   refPend_r;
  logic [7:0]             cnt_r;
  logic [7:0]             cnt_nxt;
  logic [1:0]             mrsCnt_r;
  logic [1:0]             mrsCnt_nxt;
  scru_pkg::scru_state_t  state_r;
  scru_pkg::scru_state_t  state_nxt;
  scru_pkg::scru_op_t     op_nxt;
  scru_pkg::scru_op_t     swOp;
  scru_pkg::scru_pins_t   pins;
  logic                   refStart;
  logic                   cmdIssue;
  logic                   inval;
  logic                   expire;
  logic                   refPend_nxt;
  logic                   cmdPend_nxt;
  logic                   setupOk;

  // ========================================================================
  // Byte-lane merge for partial writes.
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ========================================================================
  // Bus decode. A write takes effect on the edge that sees ack high, so the
  // master's data is stable for a full cycle before it is stored.
  wire        busHit    = cyc_i & stb_i;
  wire        wrTake    = busHit & we_i & ack_o;
  wire        selSetup  = adr_i == `SCRU_ADDR_SETUP;
  wire        selIntv   = adr_i == `SCRU_ADDR_INTERVAL;
  wire        selCmd    = adr_i == `SCRU_ADDR_COMMAND;
  wire        selStat   = adr_i == `SCRU_ADDR_STATUS;
  wire        wrSetup   = wrTake & selSetup;
  wire        wrIntv    = wrTake & selIntv;
  wire        wrCmd     = wrTake & selCmd & sel_i[0];
  wire [31:0] setupMrg  = mergeBytes(setup_r, dat_i, sel_i);
  wire [31:0] intvMrg   = mergeBytes({16'h0000, interval_r}, dat_i, sel_i);
  wire        cmdValid  = dat_i[2:0] <= `SCRU_CMD_BT;
  wire [31:0] statWord  = {27'h0000000, setupValid, ~activateOk,
                           cmdPend_r, refPend_r, state_r != scru_pkg::SCRU_ST_IDLE};

  // Read mux; the command register is write-only and reads as zero, as do
  // unmapped addresses, which are still acknowledged so no master hangs.
  wire [31:0] rdData = selSetup ? setup_r :
                       selIntv  ? {16'h0000, interval_r} :
                       selStat  ? statWord : 32'h00000000;

  // ========================================================================
  // Wishbone answer: ack one cycle after the request, dropped the next.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= busHit & ~ack_o;
      dat_o <= (busHit & ~ack_o & ~we_i) ? rdData : 32'h00000000;
    end
  end

  // ========================================================================
  // Configuration registers.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      setup_r    <= `SCRU_SETUP_RST;
      interval_r <= `SCRU_INTERVAL_RST;
    end else begin
      if (wrSetup) begin
        setup_r <= setupMrg;
      end
      if (wrIntv) begin
        interval_r <= intvMrg[15:0];
      end
    end
  end

  // Reserved size encodings: 100..111 with 64-Mbit parts, 110..111 above.
  assign setupOk = setupMrg[`SCRU_TECH64_BIT] ? ~setupMrg[2]
                                              : ~(&setupMrg[2:1]);

  // ========================================================================
  // Decoded configuration seen by the access engine, all from flops.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      casLatency3 <= 1'b0;
      memSize     <= 3'h0;
      tech64      <= 1'b0;
      setupValid  <= 1'b1;
    end else if (wrSetup) begin
      casLatency3 <= setupMrg[`SCRU_CAS3_BIT];
      memSize     <= setupMrg[`SCRU_SIZE_MSB:`SCRU_SIZE_LSB];
      tech64      <= setupMrg[`SCRU_TECH64_BIT];
      setupValid  <= setupOk;
    end
  end

  // ========================================================================
  // Refresh interval timer.
  scru_refresh_timer #(
    .W        (16)
  ) u_timer (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .interval (interval_r),
    .reload   (wrIntv),
    .expire   (expire)
  );

  // ========================================================================
  // Software command decode. Codes 110 and 111 are dropped at the write,
  // which keeps the pins quiet rather than guessing a meaning.
  always_comb begin
    case (cmdCode_r)
      `SCRU_CMD_MRS2: swOp = scru_pkg::SCRU_OP_MRS2;
      `SCRU_CMD_MRS3: swOp = scru_pkg::SCRU_OP_MRS3;
      `SCRU_CMD_PRE:  swOp = scru_pkg::SCRU_OP_PRE;
      `SCRU_CMD_NOP:  swOp = scru_pkg::SCRU_OP_NOP;
      `SCRU_CMD_AR:   swOp = scru_pkg::SCRU_OP_AR;
      `SCRU_CMD_BT:   swOp = scru_pkg::SCRU_OP_BT;
      default:        swOp = scru_pkg::SCRU_OP_DESEL;
    endcase
  end

  // ========================================================================
  // Sequencer. Refresh wins over a queued software command; neither starts
  // while a transaction runs. The expire pulse itself is looked at so that
  // an idle controller starts on the very next clock.
  always_comb begin
    state_nxt = state_r;
    op_nxt    = scru_pkg::SCRU_OP_DESEL;
    cnt_nxt   = cnt_r;
    refStart  = 1'b0;
    cmdIssue  = 1'b0;
    case (state_r)
      scru_pkg::SCRU_ST_IDLE: begin
        if (!accessBusy && (refPend_r || expire)) begin
          refStart  = 1'b1;
          op_nxt    = scru_pkg::SCRU_OP_PRE;
          state_nxt = scru_pkg::SCRU_ST_RP;
          cnt_nxt   = 8'(RP_CYC - 1);
        end else if (!accessBusy && cmdPend_r) begin
          cmdIssue  = 1'b1;
          op_nxt    = swOp;
        end
      end
      scru_pkg::SCRU_ST_RP: begin
        if (cnt_r == 8'h00) begin
          op_nxt    = scru_pkg::SCRU_OP_AR;
          state_nxt = scru_pkg::SCRU_ST_RC;
          cnt_nxt   = 8'(RC_CYC - 1);
        end else begin
          cnt_nxt   = cnt_r - 8'h01;
        end
      end
      scru_pkg::SCRU_ST_RC: begin
        if (cnt_r == 8'h00) begin
          state_nxt = scru_pkg::SCRU_ST_IDLE;
        end else begin
          cnt_nxt   = cnt_r - 8'h01;
        end
      end
      default: state_nxt = scru_pkg::SCRU_ST_IDLE;
    endcase
  end

  // Any precharge or refresh closes every bank, so the page table goes.
  assign inval = op_nxt == scru_pkg::SCRU_OP_PRE ||
                 op_nxt == scru_pkg::SCRU_OP_AR;

  // A new request in the cycle its predecessor is served is kept; a pulse
  // that starts a refresh straight from idle is used up by that start.
  assign refPend_nxt = expire ? ~(refStart & ~refPend_r)
                              : (refPend_r & ~refStart);
  assign cmdPend_nxt = (wrCmd & cmdValid) | (cmdPend_r & ~cmdIssue);

  // Mode-set guard counts down the clocks before an activate is legal.
  assign mrsCnt_nxt = (op_nxt == scru_pkg::SCRU_OP_MRS2 ||
                       op_nxt == scru_pkg::SCRU_OP_MRS3) ?
                      2'(`SCRU_MRS_GAP_CLK) :
                      (mrsCnt_r != 2'h0) ? mrsCnt_r - 2'h1 : 2'h0;

  // ========================================================================
  // Sequencer state and engine-side outputs.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r        <= scru_pkg::SCRU_ST_IDLE;
      cnt_r          <= 8'h00;
      refPend_r      <= 1'b0;
      cmdPend_r      <= 1'b0;
      cmdCode_r      <= 3'h0;
      mrsCnt_r       <= 2'h0;
      activateOk     <= 1'b1;
      pageInvalidate <= 1'b0;
      refreshBusy    <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      cnt_r          <= cnt_nxt;
      refPend_r      <= refPend_nxt;
      cmdPend_r      <= cmdPend_nxt;
      if (wrCmd && cmdValid) begin
        cmdCode_r    <= dat_i[2:0];
      end
      mrsCnt_r       <= mrsCnt_nxt;
      activateOk     <= mrsCnt_nxt == 2'h0;
      pageInvalidate <= inval;
      refreshBusy    <= refPend_nxt | (state_nxt != scru_pkg::SCRU_ST_IDLE);
    end
  end

  // ========================================================================
  // Pin encoder.
  scru_cmd_encoder #(
    .AW      (AW)
  ) u_enc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .op      (op_nxt),
    .pins    (pins),
    .addr    (sdrAddr)
  );

  assign sdrCsN  = pins.csN;
  assign sdrRasN = pins.rasN;
  assign sdrCasN = pins.casN;
  assign sdrWeN  = pins.weN;

  // ========================================================================
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_cas3;
    wrSetup |=> casLatency3 == $past(setupMrg[`SCRU_CAS3_BIT]);
  endproperty
  a_cas3: assert property (p_cas3)
    else $error("CAS delay select did not follow setup write.");

  property p_size;
    wrSetup |=> memSize == $past(setupMrg[2:0]) &&
                setupValid == $past(setupOk);
  endproperty
  a_size: assert property (p_size)
    else $error("Size select did not follow setup write.");

  property p_example;
    wrSetup && sel_i == 4'hF && dat_i == 32'h0000000D
      |=> memSize == 3'h5 && casLatency3;
  endproperty
  a_example: assert property (p_example)
    else $error("Setup example value decoded wrongly.");

  property p_idle_ref;
    state_r == scru_pkg::SCRU_ST_IDLE && expire && !accessBusy
      |=> !sdrCsN && !sdrRasN && sdrCasN && !sdrWeN && pageInvalidate;
  endproperty
  a_idle_ref: assert property (p_idle_ref)
    else $error("Refresh did not start on the next clock.");

  property p_busy_hold;
    accessBusy |=> sdrCsN;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("Command issued during a transaction.");

  property p_ar_inval;
    !sdrCsN && !sdrRasN && !sdrCasN && sdrWeN |-> pageInvalidate;
  endproperty
  a_ar_inval: assert property (p_ar_inval)
    else $error("Refresh without page invalidation.");

  property p_mrs_gap;
    !sdrCsN && !sdrRasN && !sdrCasN && !sdrWeN |-> !activateOk [*3];
  endproperty
  a_mrs_gap: assert property (p_mrs_gap)
    else $error("Activate allowed too soon after mode set.");

  property p_cmd_mrs;
    wrCmd && dat_i[2:0] == `SCRU_CMD_MRS3 && !accessBusy &&
      state_r == scru_pkg::SCRU_ST_IDLE && !refPend_r && !expire &&
      !cmdPend_r ##1 !accessBusy && !refPend_r && !expire
      |=> !sdrCsN && !sdrWeN && sdrAddr == AW'(`SCRU_MODE_CL3);
  endproperty
  a_cmd_mrs: assert property (p_cmd_mrs)
    else $error("Mode set command not launched.");

  c_refresh: cover property (pageInvalidate && refreshBusy);
  c_postpone: cover property (accessBusy && refPend_r);
  c_sw_cmd: cover property (cmdIssue && swOp == scru_pkg::SCRU_OP_BT);

endmodule

// [test/scru_sdram_model.sv]
// Far-side model: SDRAM command monitor plus a one-flag access engine.
// Assumes every signal is on ref_clk and busyReq comes from the bench.
`timescale 1ns/1ps
module scru_sdram_model (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Device pins and engine handshake
  input  wire scru_pkg::scru_pins_t pins,
  input  wire logic                 pageInvalidate,
  input  wire logic                 refreshBusy,
  input  wire logic                 busyReq,
  // Observations for the bench
  output logic                      accessBusy,
  output logic [15:0]               preGap,
  output logic [15:0]               preCnt,
  output logic [15:0]               arLag,
  output logic                      invMiss
);
  logic [15:0] cycN;
  logic [15:0] lastPre;
  // ======================================================================
  // Busy is granted only while no refresh runs, so a refresh is never cut.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      accessBusy <= 1'b0;
      cycN <= 16'h0000;
      lastPre <= 16'h0000;
      preGap <= 16'h0000;
      preCnt <= 16'h0000;
      arLag <= 16'h0000;
      invMiss <= 1'b0;
    end else begin
      cycN <= cycN + 16'h0001;
      accessBusy <= busyReq & (accessBusy | ~refreshBusy);
      if (pins == 4'h2) begin
        preGap <= cycN - lastPre;
        lastPre <= cycN;
        preCnt <= preCnt + 16'h0001;
      end
      if (pins == 4'h1) begin
        arLag <= cycN - lastPre;
      end
      if ((pins == 4'h2 || pins == 4'h1) && !pageInvalidate) begin
        invMiss <= 1'b1;
      end
    end
  end
endmodule

// [test/scru_top_tb.sv]
// Self-checking bench: Wishbone register tests, commands and refresh.
// Assumes the design's constants header and package are compiled first.
`timescale 1ns/1ps
`include "scru_cfg.svh"
module scru_top_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        busyReq = 1'b0;
  logic [31:0] adr = 32'h00000000;
  logic [31:0] dat = 32'h00000000;
  logic [3:0]  sel = 4'h0;
  logic        accessBusy, refreshBusy, pageInvalidate, activateOk, ack;
  logic        casLatency3, tech64, setupValid, csN, rasN, casN, weN;
  logic        invMiss;
  logic [2:0]  memSize;
  logic [12:0] sdrAddr;
  logic [31:0] rd, dato;
  logic [15:0] preGap, preCnt, arLag, snap;
  logic [3:0]  pinTab [6] = '{4'h0, 4'h0, 4'h2, 4'h7, 4'h1, 4'h6};
  logic [12:0] adrTab [6] = '{`SCRU_MODE_CL2, `SCRU_MODE_CL3,
                             `SCRU_PRE_ALL, 13'h0000, 13'h0000, 13'h0000};
  int          bad_count = 0;
  int          comparisons = 0;
  int          ticks = 0;
  int          n;

  scru_top #(.RP_CYC(3)) scru_top_inst (.ref_clk(ref_clk), .rst(rst),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat),
    .sel_i(sel), .dat_o(dato), .ack_o(ack), .accessBusy(accessBusy),
    .refreshBusy(refreshBusy), .pageInvalidate(pageInvalidate),
    .activateOk(activateOk), .casLatency3(casLatency3), .memSize(memSize),
    .tech64(tech64), .setupValid(setupValid), .sdrCsN(csN),
    .sdrRasN(rasN), .sdrCasN(casN), .sdrWeN(weN), .sdrAddr(sdrAddr));
  scru_sdram_model scru_sdram_model_inst (.ref_clk(ref_clk), .rst(rst),
    .pins({csN, rasN, casN, weN}), .pageInvalidate(pageInvalidate),
    .refreshBusy(refreshBusy), .busyReq(busyReq), .accessBusy(accessBusy),
    .preGap(preGap), .preCnt(preCnt), .arLag(arLag), .invMiss(invMiss));

  // ======================================================================
  // Clock, and a cycle ceiling so that a hang still ends in a verdict.
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    ticks++;
    if (ticks == 6000) begin
      bad_count++;
      end_sim();
    end
  end

  // ======================================================================
  // Shared tasks: compare, one classic bus cycle, closing report.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do @(posedge ref_clk); while (ack !== 1'b1);
    rd = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ======================================================================
  // Main sequence. Codes six and seven are never written.
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    wb(1'b0, `SCRU_ADDR_INTERVAL, 32'h0);
    chk(rd, 32'h00000384);
    wb(1'b0, `SCRU_ADDR_SETUP, 32'h0);
    chk({rd[3], casLatency3}, 2'b00);
    wb(1'b1, `SCRU_ADDR_INTERVAL, 32'h00001AB5);
    wb(1'b0, `SCRU_ADDR_INTERVAL, 32'h0);
    chk(rd, 32'h00001AB5);
    wb(1'b1, `SCRU_ADDR_INTERVAL, 32'h0);
    // The mode latency chosen below matches setup bit 3.
    wb(1'b1, `SCRU_ADDR_SETUP, 32'h0000000D);
    wb(1'b0, `SCRU_ADDR_SETUP, 32'h0);
    chk(rd, 32'h0000000D);
    chk({setupValid, tech64, casLatency3, memSize}, 6'h2D);
    wb(1'b1, `SCRU_ADDR_SETUP, 32'h00000026);
    chk({setupValid, tech64, memSize}, 5'h0E);
    wb(1'b0, 32'hCC000010, 32'h0);
    chk(rd, 32'h0);
    for (int c = 0; c < 6; c++) begin
      if (c < 2)
        wb(1'b1, `SCRU_ADDR_SETUP, (c == 1) ? 32'hD : 32'h5);
      wb(1'b1, `SCRU_ADDR_COMMAND, 32'(c));
      n = 0;
      while (csN !== 1'b0 && n < 10) begin
        @(posedge ref_clk);
        n++;
      end
      chk({csN, rasN, casN, weN}, pinTab[c]);
      chk(sdrAddr, adrTab[c]);
      chk(pageInvalidate, c == 2 || c == 4);
      for (int k = 0; k < 3; k++) begin
        chk(activateOk, c > 1);
        @(posedge ref_clk);
      end
    end
    snap = preCnt;
    repeat (300) @(posedge ref_clk);
    chk(preCnt, snap);
    wb(1'b1, `SCRU_ADDR_INTERVAL, 32'h00000040);
    repeat (230) @(posedge ref_clk);
    chk(preGap, 16'h0040);
    chk(arLag, 16'h0003);
    chk(invMiss, 1'b0);
    busyReq <= 1'b1;
    repeat (20) @(posedge ref_clk);
    snap = preCnt;
    repeat (150) @(posedge ref_clk);
    chk(preCnt, snap);
    chk(refreshBusy, 1'b1);
    wb(1'b0, `SCRU_ADDR_STATUS, 32'h0);
    chk(rd, 32'h00000012);
    busyReq <= 1'b0;
    n = 0;
    while (preCnt == snap && n < 10) begin
      @(posedge ref_clk);
      n++;
    end
    chk(preCnt, snap + 16'h0001);
    repeat (16) @(posedge ref_clk);
    chk(refreshBusy, 1'b0);
    end_sim();
  end
endmodule
